// >>> design/tcm_timers.sv
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Each timer: 16-bit count, two writable bytes
// - Separate two-bit mode field per timer
// - Mode 0: high byte plus low five bits
// - Mode 0 wrap sets overflow flag
// - Interrupt request only with its own enable
// - Counter select: count falling pin edges
// - Timer select: system clock or prescaler
// - Prescaler: /12, /4, /4, external /8
// - Count only when run and gate allow
// - Input zero gates timer 0, one timer 1
// - Starting run never resets the count
// - Mode 1: same as mode 0, sixteen bits
// - Mode 2: low byte reloads from high
// - Split: timer 0 low uses timer 0 controls
// - Split: high byte runs on timer 1 run
// - Split: timer 1 internal clock, no flag
// - Timer 1 mode 3 stops timer 1
// - Flag cleared by write or vectoring
// - Pins sampled by system clock, two-cycle levels
module tcm_timers
  import tcm_pkg::*;
(
  input  wire logic     clk,
  input  wire logic     nrst,
  input  wire tcm_ctl_t timer_zero_ctl,
  input  wire tcm_ctl_t timer_one_ctl,
  input  wire logic [1:0] prescale_select,
  input  wire tcm_wr_t  sw_write,
  input  wire logic     timer_zero_count_pin,
  input  wire logic     timer_one_count_pin,
  input  wire logic     external_input_zero,
  input  wire logic     external_input_one,
  input  wire logic     external_clock,
  output logic [7:0]    timer_zero_low_byte,
  output logic [7:0]    timer_zero_high_byte,
  output logic [7:0]    timer_one_low_byte,
  output logic [7:0]    timer_one_high_byte,
  output logic          timer_zero_overflow_flag,
  output logic          timer_one_overflow_flag,
  output logic          timer_zero_irq,
  output logic          timer_one_irq,
  output logic          timer_one_overflow_pulse
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic tcm_gate_open(tcm_ctl_t c, logic in_lvl);
    return c.run_bit & (~c.gate_bit | (in_lvl == c.polarity));
  endfunction

  function automatic logic tcm_tick(tcm_ctl_t c, logic fall, logic pre);
    logic t;
    t = c.sysclk_select ? 1'b1 : pre;
    return c.counter_select ? fall : t;
  endfunction

  // Returns {overflow, high byte, low byte} after one count
  function automatic logic [16:0] tcm_step(tcm_mode_t m, logic [7:0] lo,
                                           logic [7:0] hi);
    logic [12:0] v13;
    logic [15:0] v16;
    logic [16:0] r;
    v13 = {hi, lo[4:0]};
    v16 = {hi, lo};
    r   = {1'b0, hi, lo};
    case (m)
      TCM_MODE_13BIT: begin
        r = {(v13 == TCM_ONES13), 8'h00, lo[7:5], 5'h00};
        v13 = v13 + 13'h0001;
        r[15:8] = v13[12:5];
        r[4:0]  = v13[4:0];
      end
      TCM_MODE_16BIT: begin
        r = {(v16 == TCM_ONES16), v16 + 16'h0001};
      end
      TCM_MODE_8RELOAD: begin
        if (lo == TCM_ONES8) begin
          r = {1'b1, hi, hi};
        end else begin
          r = {1'b0, hi, lo + 8'h01};
        end
      end
      default: begin
        r = {(lo == TCM_ONES8), hi, lo + 8'h01};
      end
    endcase
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Input synchronisation
  // ----------------------------------------------------------------
  logic [4:0] sync_in;
  logic [4:0] sync_q;

  assign sync_in = {external_clock, external_input_one, external_input_zero,
                    timer_one_count_pin, timer_zero_count_pin};

  tcm_sync u_sync (
    .clk  (clk),
    .nrst (nrst),
    .din  (sync_in),
    .dout (sync_q)
  );

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  tcm_state_t s;
  tcm_state_t next_s;

  logic        fall0;
  logic        fall1;
  logic        ext_rise;
  logic        pre_tick;
  logic        split;
  logic        en0;
  logic        en0_high;
  logic        en1;
  logic        ovf0;
  logic        ovf0_high;
  logic        ovf1;
  logic        tick1;
  logic [16:0] step0;
  logic [16:0] step1;

  always_comb begin
    next_s    = s;
    ovf0      = 1'b0;
    ovf0_high = 1'b0;
    ovf1      = 1'b0;
    pre_tick  = 1'b0;
    step0     = '0;
    step1     = '0;

    // Edge detection on synchronised samples
    fall0    = s.sync_last[TCM_SYNC_PIN0] & ~sync_q[TCM_SYNC_PIN0];
    fall1    = s.sync_last[TCM_SYNC_PIN1] & ~sync_q[TCM_SYNC_PIN1];
    ext_rise = ~s.sync_last[TCM_SYNC_EXTCLK] & sync_q[TCM_SYNC_EXTCLK];
    next_s.sync_last = sync_q;

    // --------------------------------------------------------------
    // Shared prescaler
    // --------------------------------------------------------------
    case (prescale_select)
      TCM_SCA_SYS_DIV12: begin
        if (s.pre_cnt >= TCM_PRE12_LAST) begin
          next_s.pre_cnt = TCM_PRE_RESET;
          pre_tick       = 1'b1;
        end else begin
          next_s.pre_cnt = s.pre_cnt + 4'h1;
        end
      end
      TCM_SCA_SYS_DIV4A, TCM_SCA_SYS_DIV4B: begin
        if (s.pre_cnt >= TCM_PRE4_LAST) begin
          next_s.pre_cnt = TCM_PRE_RESET;
          pre_tick       = 1'b1;
        end else begin
          next_s.pre_cnt = s.pre_cnt + 4'h1;
        end
      end
      default: begin
        if (ext_rise) begin
          if (s.ext_cnt == TCM_EXT8_LAST) begin
            next_s.ext_cnt = TCM_EXT_RESET;
            pre_tick       = 1'b1;
          end else begin
            next_s.ext_cnt = s.ext_cnt + 3'h1;
          end
        end
      end
    endcase

    // --------------------------------------------------------------
    // Count enables
    // --------------------------------------------------------------
    split = (timer_zero_ctl.mode == TCM_MODE_SPLIT);
    en0   = tcm_gate_open(timer_zero_ctl, sync_q[TCM_SYNC_INPUT0])
            & tcm_tick(timer_zero_ctl, fall0, pre_tick);
    // Split high byte: internal clock only, run by timer 1 run bit
    en0_high = split & timer_one_ctl.run_bit
               & (timer_zero_ctl.sysclk_select | pre_tick);
    // Split mode forces timer 1 onto its internal clock
    tick1 = split ? (timer_one_ctl.sysclk_select | pre_tick)
                  : tcm_tick(timer_one_ctl, fall1, pre_tick);
    en1   = (timer_one_ctl.mode != TCM_MODE_SPLIT)
            & tcm_gate_open(timer_one_ctl, sync_q[TCM_SYNC_INPUT1])
            & tick1;

    // --------------------------------------------------------------
    // Timer 0
    // --------------------------------------------------------------
    // Counting continues from the held value when run is set
    if (en0) begin
      step0 = tcm_step(timer_zero_ctl.mode,
                       s.count_bytes[TCM_BYTE_T0_LOW],
                       s.count_bytes[TCM_BYTE_T0_HIGH]);
      ovf0  = step0[16];
      next_s.count_bytes[TCM_BYTE_T0_LOW] = step0[7:0];
      if (!split) begin
        next_s.count_bytes[TCM_BYTE_T0_HIGH] = step0[15:8];
      end
    end
    if (en0_high) begin
      ovf0_high = (s.count_bytes[TCM_BYTE_T0_HIGH] == TCM_ONES8);
      next_s.count_bytes[TCM_BYTE_T0_HIGH] =
        s.count_bytes[TCM_BYTE_T0_HIGH] + 8'h01;
    end

    // --------------------------------------------------------------
    // Timer 1
    // --------------------------------------------------------------
    if (en1) begin
      step1 = tcm_step(timer_one_ctl.mode,
                       s.count_bytes[TCM_BYTE_T1_LOW],
                       s.count_bytes[TCM_BYTE_T1_HIGH]);
      ovf1  = step1[16];
      next_s.count_bytes[TCM_BYTE_T1_LOW]  = step1[7:0];
      next_s.count_bytes[TCM_BYTE_T1_HIGH] = step1[15:8];
    end
    // Overflow pulse still feeds downstream consumers in split mode
    next_s.t1_ovf_pulse = ovf1;

    // --------------------------------------------------------------
    // Software byte writes take priority over counting
    // --------------------------------------------------------------
    for (int i = 0; i < TCM_NUM_BYTES; i++) begin
      if (sw_write.byte_wr[i]) begin
        next_s.count_bytes[i] = sw_write.byte_data;
      end
    end

    // --------------------------------------------------------------
    // Overflow flags: hardware set beats any clear
    // --------------------------------------------------------------
    if (sw_write.flag_wr[0]) begin
      next_s.ovf_flag[0] = sw_write.flag_data[0];
    end
    if (sw_write.isr_vector[0]) begin
      next_s.ovf_flag[0] = 1'b0;
    end
    if (ovf0) begin
      next_s.ovf_flag[0] = 1'b1;
    end
    if (sw_write.flag_wr[1]) begin
      next_s.ovf_flag[1] = sw_write.flag_data[1];
    end
    if (sw_write.isr_vector[1]) begin
      next_s.ovf_flag[1] = 1'b0;
    end
    if (split ? ovf0_high : ovf1) begin
      next_s.ovf_flag[1] = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s <= '{count_bytes: {4{TCM_BYTE_RESET}},
             ovf_flag:    2'h0,
             sync_last:   TCM_SYNC_RESET,
             pre_cnt:     TCM_PRE_RESET,
             ext_cnt:     TCM_EXT_RESET,
             t1_ovf_pulse: 1'b0};
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign timer_zero_low_byte      = s.count_bytes[TCM_BYTE_T0_LOW];
  assign timer_zero_high_byte     = s.count_bytes[TCM_BYTE_T0_HIGH];
  assign timer_one_low_byte       = s.count_bytes[TCM_BYTE_T1_LOW];
  assign timer_one_high_byte      = s.count_bytes[TCM_BYTE_T1_HIGH];
  assign timer_zero_overflow_flag = s.ovf_flag[0];
  assign timer_one_overflow_flag  = s.ovf_flag[1];
  assign timer_zero_irq = s.ovf_flag[0] & timer_zero_ctl.irq_enable;
  assign timer_one_irq  = s.ovf_flag[1] & timer_one_ctl.irq_enable;
  assign timer_one_overflow_pulse = s.t1_ovf_pulse;

endmodule // tcm_timers

`default_nettype wire

// >>> design/tcm_pkg.sv
`default_nettype none

package tcm_pkg;

  // ----------------------------------------------------------------
  // Operating modes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    TCM_MODE_13BIT   = 2'b00,
    TCM_MODE_16BIT   = 2'b01,
    TCM_MODE_8RELOAD = 2'b10,
    TCM_MODE_SPLIT   = 2'b11
  } tcm_mode_t;

  // ----------------------------------------------------------------
  // Prescaler selection and division
  // ----------------------------------------------------------------
  localparam logic [1:0] TCM_SCA_SYS_DIV12 = 2'h0;
  localparam logic [1:0] TCM_SCA_SYS_DIV4A = 2'h1;
  localparam logic [1:0] TCM_SCA_SYS_DIV4B = 2'h2;
  localparam logic [1:0] TCM_SCA_EXT_DIV8  = 2'h3;

  localparam int TCM_DIV_SYS12 = 12;
  localparam int TCM_DIV_SYS4  = 4;
  localparam int TCM_DIV_EXT8  = 8;

  localparam logic [3:0] TCM_PRE12_LAST = 4'(TCM_DIV_SYS12 - 1);
  localparam logic [3:0] TCM_PRE4_LAST  = 4'(TCM_DIV_SYS4 - 1);
  localparam logic [2:0] TCM_EXT8_LAST  = 3'(TCM_DIV_EXT8 - 1);

  // ----------------------------------------------------------------
  // Count limits, reset values, indices
  // ----------------------------------------------------------------
  localparam logic [12:0] TCM_ONES13     = 13'h1FFF;
  localparam logic [15:0] TCM_ONES16     = 16'hFFFF;
  localparam logic [7:0]  TCM_ONES8      = 8'hFF;
  localparam logic [7:0]  TCM_BYTE_RESET = 8'h00;
  localparam logic [3:0]  TCM_PRE_RESET  = 4'h0;
  localparam logic [2:0]  TCM_EXT_RESET  = 3'h0;

  localparam int TCM_BYTE_T0_LOW  = 0;
  localparam int TCM_BYTE_T0_HIGH = 1;
  localparam int TCM_BYTE_T1_LOW  = 2;
  localparam int TCM_BYTE_T1_HIGH = 3;
  localparam int TCM_NUM_BYTES    = 4;

  localparam int TCM_SYNC_WIDTH   = 5;
  localparam int TCM_SYNC_PIN0    = 0;
  localparam int TCM_SYNC_PIN1    = 1;
  localparam int TCM_SYNC_INPUT0  = 2;
  localparam int TCM_SYNC_INPUT1  = 3;
  localparam int TCM_SYNC_EXTCLK  = 4;
  localparam logic [4:0] TCM_SYNC_RESET = 5'h00;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic      run_bit;
    logic      gate_bit;
    logic      counter_select;
    logic      sysclk_select;
    tcm_mode_t mode;
    logic      polarity;
    logic      irq_enable;
  } tcm_ctl_t;

  typedef struct packed {
    logic [3:0] byte_wr;
    logic [7:0] byte_data;
    logic [1:0] flag_wr;
    logic [1:0] flag_data;
    logic [1:0] isr_vector;
  } tcm_wr_t;

  typedef struct packed {
    logic [3:0][7:0] count_bytes;
    logic [1:0]      ovf_flag;
    logic [4:0]      sync_last;
    logic [3:0]      pre_cnt;
    logic [2:0]      ext_cnt;
    logic            t1_ovf_pulse;
  } tcm_state_t;

  typedef struct packed {
    logic [4:0] stage_one;
    logic [4:0] stage_two;
  } tcm_sync_t;

endpackage

`default_nettype wire

// >>> design/tcm_sync.sv
`timescale 1ns/1ps
`default_nettype none

module tcm_sync
  import tcm_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic [4:0] din,
  output logic      [4:0] dout
);

  // ----------------------------------------------------------------
  // Two-stage synchroniser, first stage feeds only the second
  // ----------------------------------------------------------------
  tcm_sync_t s;
  tcm_sync_t next_s;

  always_comb begin
    next_s           = s;
    next_s.stage_one = din;
    next_s.stage_two = s.stage_one;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s <= '{stage_one: TCM_SYNC_RESET, stage_two: TCM_SYNC_RESET};
    end else begin
      s <= next_s;
    end
  end

  assign dout = s.stage_two;

endmodule // tcm_sync

`default_nettype wire

// >>> sim/tcm_timers_asserts.sv
`timescale 1ns/1ps
`default_nettype none

module tcm_timers_asserts
  import tcm_pkg::*;
(
  input wire logic       clk,
  input wire logic       nrst,
  input wire tcm_ctl_t   timer_zero_ctl,
  input wire tcm_ctl_t   timer_one_ctl,
  input wire tcm_wr_t    sw_write,
  input wire logic [7:0] timer_zero_low_byte,
  input wire logic [7:0] timer_zero_high_byte,
  input wire logic [7:0] timer_one_low_byte,
  input wire logic [7:0] timer_one_high_byte,
  input wire logic       timer_zero_overflow_flag,
  input wire logic       timer_one_overflow_flag,
  input wire logic       timer_zero_irq,
  input wire logic       timer_one_irq,
  input wire logic       timer_one_overflow_pulse
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  logic t0_free;
  logic t1_free;
  logic no_wr;
  assign t0_free = timer_zero_ctl.run_bit && !timer_zero_ctl.gate_bit &&
                   !timer_zero_ctl.counter_select &&
                   timer_zero_ctl.sysclk_select;
  assign t1_free = timer_one_ctl.run_bit && !timer_one_ctl.gate_bit &&
                   !timer_one_ctl.counter_select &&
                   timer_one_ctl.sysclk_select;
  assign no_wr = (sw_write.byte_wr == 4'h0);

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  sequence s_pulse_once;
    timer_one_overflow_pulse ##1 !timer_one_overflow_pulse;
  endsequence

  property p_byte_write;
    sw_write.byte_wr[1] |=> timer_zero_high_byte == $past(sw_write.byte_data);
  endproperty
  property p_irq_zero;
    timer_zero_irq == (timer_zero_overflow_flag && timer_zero_ctl.irq_enable);
  endproperty
  property p_irq_one;
    timer_one_irq == (timer_one_overflow_flag && timer_one_ctl.irq_enable);
  endproperty
  property p_hold_zero;
    !timer_zero_ctl.run_bit && !sw_write.byte_wr[0]
      |=> $stable(timer_zero_low_byte);
  endproperty
  property p_t1_stop;
    timer_one_ctl.mode == TCM_MODE_SPLIT && sw_write.byte_wr[3:2] == 2'h0
      |=> $stable({timer_one_high_byte, timer_one_low_byte});
  endproperty
  property p_wrap13;
    t0_free && timer_zero_ctl.mode == TCM_MODE_13BIT && no_wr &&
    timer_zero_high_byte == 8'hFF && timer_zero_low_byte[4:0] == 5'h1F
      |=> timer_zero_high_byte == 8'h00 &&
          timer_zero_low_byte[4:0] == 5'h00 && timer_zero_overflow_flag;
  endproperty
  property p_wrap16;
    t1_free && timer_one_ctl.mode == TCM_MODE_16BIT && no_wr &&
    timer_zero_ctl.mode != TCM_MODE_SPLIT &&
    {timer_one_high_byte, timer_one_low_byte} == 16'hFFFF
      |=> ({timer_one_high_byte, timer_one_low_byte} == 16'h0000 &&
           timer_one_overflow_flag) and s_pulse_once;
  endproperty
  property p_reload;
    t0_free && timer_zero_ctl.mode == TCM_MODE_8RELOAD && no_wr &&
    timer_zero_low_byte == 8'hFF
      |=> timer_zero_low_byte == $past(timer_zero_high_byte) &&
          $stable(timer_zero_high_byte) && timer_zero_overflow_flag;
  endproperty
  property p_split_high;
    timer_one_ctl.run_bit && timer_zero_ctl.mode == TCM_MODE_SPLIT &&
    timer_zero_ctl.sysclk_select && no_wr && timer_zero_high_byte == 8'hFF
      |=> timer_zero_high_byte == 8'h00 && timer_one_overflow_flag;
  endproperty
  property p_isr_clear;
    sw_write.isr_vector[0] && !sw_write.flag_wr[0] &&
    !timer_zero_ctl.run_bit |=> !timer_zero_overflow_flag;
  endproperty

  a_byte_write: assert property (p_byte_write)
    else $error("high byte write not taken");
  a_irq_zero: assert property (p_irq_zero)
    else $error("timer zero irq wrong");
  a_irq_one: assert property (p_irq_one)
    else $error("timer one irq wrong");
  a_hold_zero: assert property (p_hold_zero)
    else $error("stopped timer zero counted");
  a_t1_stop: assert property (p_t1_stop)
    else $error("timer one counted in mode 3");
  a_wrap13: assert property (p_wrap13)
    else $error("mode 0 wrap wrong");
  a_wrap16: assert property (p_wrap16)
    else $error("mode 1 wrap wrong");
  a_reload: assert property (p_reload)
    else $error("mode 2 reload wrong");
  a_split_high: assert property (p_split_high)
    else $error("split high byte overflow wrong");
  a_isr_clear: assert property (p_isr_clear)
    else $error("flag not cleared on vectoring");
endmodule // tcm_timers_asserts

`default_nettype wire

// >>> sim/tcm_timers_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tcm_timers_tb_top
  import tcm_pkg::*;
;
  logic        clk, nrst, pin0, pin1, in0, in1;
  logic        ext = 1'b0;
  tcm_ctl_t    c0, c1;
  tcm_wr_t     sw;
  logic [1:0]  sca;
  logic [7:0]  l0, h0, l1, h1;
  logic        f0, f1, q0, q1, pulse;
  logic [15:0] v;
  int          n_fail = 0;
  int          num_checks = 0;
  int          cyc = 0;
  int          n, k;
  int          per [5] = '{24, 8, 8, 64, 2};

  tcm_timers DUT (
    .clk(clk), .nrst(nrst), .timer_zero_ctl(c0), .timer_one_ctl(c1),
    .prescale_select(sca), .sw_write(sw), .timer_zero_count_pin(pin0),
    .timer_one_count_pin(pin1), .external_input_zero(in0),
    .external_input_one(in1), .external_clock(ext),
    .timer_zero_low_byte(l0), .timer_zero_high_byte(h0),
    .timer_one_low_byte(l1), .timer_one_high_byte(h1),
    .timer_zero_overflow_flag(f0), .timer_one_overflow_flag(f1),
    .timer_zero_irq(q0), .timer_one_irq(q1),
    .timer_one_overflow_pulse(pulse));

  // ----------------------------------------------------------------
  // Clocks and watchdog
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always begin
    repeat (2) @(posedge clk);
    #1;
    ext = ~ext;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      n_fail++;
      complete_run();
    end
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic tick(input int t);
    repeat (t) @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic swp(input tcm_wr_t w);
    sw = w;
    tick(1);
    sw = '0;
    tick(1);
  endtask
  task automatic wrb(input int i, input logic [7:0] d);
    swp('{4'(1 << i), d, 2'h0, 2'h0, 2'h0});
  endtask
  task automatic clrf;
    swp('{4'h0, 8'h00, 2'h3, 2'h0, 2'h0});
  endtask
  function automatic tcm_ctl_t mk(input int r, g, cs, s,
                                  input tcm_mode_t m, input int p, e);
    return '{1'(r), 1'(g), 1'(cs), 1'(s), m, 1'(p), 1'(e)};
  endfunction
  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    nrst = 1'b0;
    c0 = '0;
    c1 = '0;
    sw = '0;
    sca = 2'h0;
    pin0 = 1'b1;
    pin1 = 1'b0;
    in0 = 1'b0;
    in1 = 1'b0;
    tick(5);
    nrst = 1'b1;
    chk({h0, l0, h1, l1} == 32'h0, 16'h0001);
    chk(16'({f0, f1, q0, q1, pulse}), 16'h0000);
    $display("test reset done");
    wrb(1, 8'hFF);
    wrb(0, 8'hFE);
    c0 = mk(1, 0, 0, 1, TCM_MODE_13BIT, 1, 1);
    tick(2);
    chk({h0, l0 & 8'h1F}, 16'h0000);
    chk(16'({f0, q0}), 16'h0003);
    c0 = mk(0, 0, 0, 1, TCM_MODE_13BIT, 1, 1);
    swp('{4'h0, 8'h00, 2'h0, 2'h0, 2'h1});
    chk(16'(f0), 16'h0000);
    $display("test mode 0 done");
    wrb(2, 8'hFF);
    wrb(3, 8'hFF);
    c1 = mk(1, 0, 0, 1, TCM_MODE_16BIT, 1, 0);
    tick(1);
    chk({h1, l1}, 16'h0000);
    chk(16'({f1, q1, pulse}), 16'h0005);
    c1 = mk(0, 0, 0, 1, TCM_MODE_16BIT, 1, 0);
    clrf();
    chk(16'(f1), 16'h0000);
    $display("test mode 1 done");
    wrb(1, 8'h80);
    for (k = 0; k < 5; k++) begin
      c0 = mk(0, 0, 0, int'(k == 4), TCM_MODE_8RELOAD, 1, 0);
      wrb(0, 8'hFE);
      clrf();
      sca = 2'(k % 4);
      c0 = mk(1, 0, 0, int'(k == 4), TCM_MODE_8RELOAD, 1, 0);
      n = 0;
      while (f0 !== 1'b1 && n < 400) begin
        tick(1);
        n++;
      end
      n = 0;
      while (l0 !== 8'h82 && n < 400) begin
        tick(1);
        n++;
      end
      chk(16'(n), 16'(per[k]));
      chk({h0, l0}, 16'h8082);
    end
    $display("test mode 2 done");
    for (k = 0; k < 2; k++) begin
      c0 = mk(0, 1, 0, 1, TCM_MODE_16BIT, k, 0);
      in0 = ~k[0];
      tick(4);
      v = {h0, l0};
      c0 = mk(1, 1, 0, 1, TCM_MODE_16BIT, k, 0);
      tick(6);
      chk({h0, l0}, v);
      in0 = k[0];
      tick(6);
      chk(16'({h0, l0} !== v), 16'h0001);
    end
    $display("test gate done");
    c0 = mk(0, 0, 1, 1, TCM_MODE_16BIT, 1, 0);
    pin1 = 1'b1;
    in1 = 1'b1;
    wrb(0, 8'h00);
    wrb(1, 8'h00);
    wrb(2, 8'h00);
    wrb(3, 8'h00);
    c0 = mk(1, 0, 1, 1, TCM_MODE_16BIT, 1, 0);
    c1 = mk(1, 1, 1, 0, TCM_MODE_16BIT, 1, 0);
    repeat (5) begin
      pin0 = 1'b0;
      pin1 = 1'b0;
      tick(3);
      pin0 = 1'b1;
      pin1 = 1'b1;
      tick(3);
    end
    tick(4);
    chk({h0, l0}, 16'h0005);
    chk({h1, l1}, 16'h0005);
    in1 = 1'b0;
    tick(3);
    pin1 = 1'b0;
    tick(3);
    pin1 = 1'b1;
    tick(4);
    chk({h1, l1}, 16'h0005);
    c1 = '0;
    $display("test pin done");
    c0 = mk(0, 0, 0, 1, TCM_MODE_SPLIT, 1, 0);
    wrb(0, 8'h10);
    wrb(1, 8'hFE);
    wrb(2, 8'h55);
    wrb(3, 8'h55);
    c1 = mk(0, 0, 0, 1, TCM_MODE_SPLIT, 1, 1);
    clrf();
    c0 = mk(1, 0, 0, 1, TCM_MODE_SPLIT, 1, 0);
    c1 = mk(1, 0, 0, 1, TCM_MODE_SPLIT, 1, 1);
    tick(2);
    chk({h0, l0}, 16'h0012);
    chk(16'({f0, f1, q1}), 16'h0003);
    chk({h1, l1}, 16'h5555);
    c0 = mk(0, 0, 0, 1, TCM_MODE_SPLIT, 1, 0);
    c1 = mk(0, 0, 0, 1, TCM_MODE_SPLIT, 1, 1);
    wrb(1, 8'h00);
    wrb(2, 8'hFF);
    wrb(3, 8'hFF);
    swp('{4'h0, 8'h00, 2'h0, 2'h0, 2'h2});
    chk(16'(f1), 16'h0000);
    c1 = mk(1, 0, 1, 1, TCM_MODE_16BIT, 1, 1);
    tick(1);
    chk({h1, l1}, 16'h0000);
    chk(16'({f1, pulse}), 16'h0001);
    $display("test split done");
    complete_run();
  end
endmodule // tcm_timers_tb_top

bind tcm_timers tcm_timers_asserts u_chk (
  .clk(clk), .nrst(nrst), .timer_zero_ctl(timer_zero_ctl),
  .timer_one_ctl(timer_one_ctl), .sw_write(sw_write),
  .timer_zero_low_byte(timer_zero_low_byte),
  .timer_zero_high_byte(timer_zero_high_byte),
  .timer_one_low_byte(timer_one_low_byte),
  .timer_one_high_byte(timer_one_high_byte),
  .timer_zero_overflow_flag(timer_zero_overflow_flag),
  .timer_one_overflow_flag(timer_one_overflow_flag),
  .timer_zero_irq(timer_zero_irq), .timer_one_irq(timer_one_irq),
  .timer_one_overflow_pulse(timer_one_overflow_pulse));

`default_nettype wire
